/* common/fpp_pkg.sv */
/*
 * Holds the constants shared by the parallel programmer mode flash
 * sequencer: command codes, status bit positions, reset values and
 * timing counts derived from a 100 MHz system clock.
 * Assumes it is compiled before every design file that names it.
 */
package fpp_pkg;

    // System clock rate in hertz.
    localparam int unsigned CLK_HZ = 100_000_000;

    // Command codes written on the data lines.
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_STATUS = 8'h71;

    // Filler byte for unused program positions and erased cells.
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // Status byte bit positions.
    localparam int unsigned ST_ABNORMAL = 7;
    localparam int unsigned ST_CMD_ERR = 6;
    localparam int unsigned ST_PROG_ERR = 5;
    localparam int unsigned ST_ERASE_ERR = 4;
    localparam int unsigned ST_COUNT_ERR = 1;
    localparam int unsigned ST_ADDR_ERR = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // Page geometry: bytes programmed together, and write cycles taken.
    localparam int unsigned PAGE_BYTES = 128;
    localparam int unsigned PROGRAM_CYCLES = 129;

    // Settling times in milliseconds, and their cycle counts.
    localparam int unsigned OSC_SETTLE_MS = 20;
    localparam int unsigned MODE_SETUP_MS = 10;
    localparam int unsigned OSC_SETTLE_CYC = OSC_SETTLE_MS * (CLK_HZ / 1000);
    localparam int unsigned MODE_SETUP_CYC = MODE_SETUP_MS * (CLK_HZ / 1000);

    // Internal array operation times in microseconds (kept short).
    localparam int unsigned WRITE_TIME_US = 1000;
    localparam int unsigned ERASE_TIME_US = 100000;
    localparam int unsigned WRITE_CYC = WRITE_TIME_US * (CLK_HZ / 1000000);
    localparam int unsigned ERASE_CYC = ERASE_TIME_US * (CLK_HZ / 1000000);

endpackage

/* hdl/fpp_mem.sv */
/*
 * Holds the flash cell array as a synchronous single port memory.
 * Assumes one access per cycle; read data come from a register.
 */
module fpp_mem #(
    parameter int unsigned AW = 17
) (
    input wire logic sys_clk_in,
    input wire logic we_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out
);

    logic [7:0] cell_ff [0:(1<<AW)-1];

    ////////////////////////////////////////////////////////////////////
    // Write on request; always register the addressed byte.
    always_ff @(posedge sys_clk_in) begin
        if (we_in) begin
            cell_ff[addr_in] <= wdata_in;
        end
        rdata_out <= cell_ff[addr_in];
    end

endmodule

/* hdl/fpp_top.sv */
/*
 * Device side of the byte wide flash programming port: strobe decode,
 * command sequencer, page buffer, array program and erase, status.
 * Assumes the port strobes are already synchronous to sys_clk_in and
 * that the programmer keeps its own timing and sequencing duties.
 */

module fpp_top #(
    parameter int unsigned AW = 17,
    parameter int unsigned FLASH_BYTES = 131072,
    parameter int unsigned OSC_CYC = fpp_pkg::OSC_SETTLE_CYC,
    parameter int unsigned SETUP_CYC = fpp_pkg::MODE_SETUP_CYC,
    parameter int unsigned PROG_CYC = fpp_pkg::WRITE_CYC,
    parameter int unsigned ERASE_CYC = fpp_pkg::ERASE_CYC
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic write_n_in,
    input wire logic write_protect_release_pin_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_out,
    output logic ready_out,
    output logic busy_out
);

    typedef enum logic [3:0] {
        S_OSC, S_SETUP, S_READ, S_CMD2, S_LOAD, S_PROG, S_ERASE,
        S_POLL, S_STATUS
    } fpp_state_e;

    typedef struct packed {
        fpp_state_e state;
        logic [31:0] timer;
        logic [7:0] first_cmd;
        logic [7:0] count;
        logic [AW-1:0] page_addr;
        logic [AW-1:0] op_addr;
        logic [7:0] status;
        logic done;
        logic we_d;
        logic [7:0] rd_byte;
    } fpp_regs_s;

    fpp_regs_s cur_ff;
    fpp_regs_s nxt_ff;

    logic [7:0] page_buf_ff [0:fpp_pkg::PAGE_BYTES-1];
    logic mem_we;
    logic [AW-1:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic wr_edge;

    // Returns true when the address lies outside the populated array.
    function automatic logic addr_bad(input logic [AW-1:0] a);
        addr_bad = ({1'b0, a} >= (AW+1)'(FLASH_BYTES));
    endfunction

    ////////////////////////////////////////////////////////////////////
    // A write cycle is taken on the rising edge of the write strobe.
    assign wr_edge = cur_ff.we_d && write_n_in && !chip_sel_n_in;

    ////////////////////////////////////////////////////////////////////
    // Memory port: program and erase own it, otherwise reads follow
    // the address lines.
    always_comb begin
        mem_we = 1'b0;
        mem_addr = addr_in;
        mem_wdata = fpp_pkg::ERASED_BYTE;
        if (cur_ff.state == S_PROG) begin
            mem_we = !cur_ff.status[fpp_pkg::ST_ADDR_ERR];
            mem_addr = cur_ff.op_addr;
            mem_wdata = page_buf_ff[cur_ff.op_addr[6:0]];
        end else if (cur_ff.state == S_ERASE) begin
            mem_we = 1'b1;
            mem_addr = cur_ff.op_addr;
        end
    end

    fpp_mem #(
        .AW(AW)
    ) u_mem (
        .sys_clk_in(sys_clk_in),
        .we_in(mem_we),
        .addr_in(mem_addr),
        .wdata_in(mem_wdata),
        .rdata_out(mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////
    // Page buffer collects the 128 data bytes of a program command.
    always_ff @(posedge sys_clk_in) begin
        if (cur_ff.state == S_CMD2 && wr_edge &&
            cur_ff.first_cmd == fpp_pkg::CMD_PROGRAM) begin
            // The page address write also carries the first data byte.
            page_buf_ff[0] <= data_in;
        end else if (cur_ff.state == S_LOAD && wr_edge) begin
            page_buf_ff[cur_ff.count[6:0]] <= data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sequencer next state.
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.we_d = !write_n_in;
        nxt_ff.rd_byte = mem_rdata;
        case (cur_ff.state)
            S_OSC: begin
                // Writes are ignored while the oscillator settles.
                if (cur_ff.timer >= OSC_CYC - 1) begin
                    nxt_ff.timer = '0;
                    nxt_ff.state = S_SETUP;
                end else begin
                    nxt_ff.timer = cur_ff.timer + 32'h1;
                end
            end
            S_SETUP: begin
                if (cur_ff.timer >= SETUP_CYC - 1) begin
                    nxt_ff.timer = '0;
                    nxt_ff.state = S_READ;
                end else begin
                    nxt_ff.timer = cur_ff.timer + 32'h1;
                end
            end
            S_READ, S_POLL, S_STATUS: begin
                if (wr_edge) begin
                    nxt_ff.first_cmd = data_in;
                    case (data_in)
                        fpp_pkg::CMD_READ: nxt_ff.state = S_READ;
                        fpp_pkg::CMD_PROGRAM, fpp_pkg::CMD_ERASE: begin
                            if (write_protect_release_pin_in) begin
                                nxt_ff.state = S_CMD2;
                            end else begin
                                nxt_ff.status[fpp_pkg::ST_CMD_ERR] = 1'b1;
                                nxt_ff.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                            end
                        end
                        fpp_pkg::CMD_STATUS: nxt_ff.state = S_CMD2;
                        default: begin
                            nxt_ff.status[fpp_pkg::ST_CMD_ERR] = 1'b1;
                            nxt_ff.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                        end
                    endcase
                end
            end
            S_CMD2: begin
                if (wr_edge) begin
                    if (cur_ff.first_cmd == fpp_pkg::CMD_PROGRAM) begin
                        // Status clears only at reset or as a new operation begins.
                        nxt_ff.status = fpp_pkg::STATUS_RESET;
                        nxt_ff.page_addr = {addr_in[AW-1:7], 7'h00};
                        nxt_ff.status[fpp_pkg::ST_ADDR_ERR] =
                            addr_bad(addr_in);
                        nxt_ff.status[fpp_pkg::ST_PROG_ERR] =
                            addr_bad(addr_in);
                        nxt_ff.status[fpp_pkg::ST_ABNORMAL] =
                            addr_bad(addr_in);
                        nxt_ff.count = 8'h01;
                        nxt_ff.state = S_LOAD;
                    end else if (cur_ff.first_cmd == fpp_pkg::CMD_ERASE &&
                                 data_in == fpp_pkg::CMD_ERASE) begin
                        nxt_ff.status = fpp_pkg::STATUS_RESET;
                        nxt_ff.op_addr = '0;
                        nxt_ff.timer = '0;
                        nxt_ff.done = 1'b0;
                        nxt_ff.state = S_ERASE;
                    end else if (cur_ff.first_cmd == fpp_pkg::CMD_STATUS &&
                                 data_in == fpp_pkg::CMD_STATUS) begin
                        nxt_ff.state = S_STATUS;
                    end else begin
                        nxt_ff.status[fpp_pkg::ST_CMD_ERR] = 1'b1;
                        nxt_ff.status[fpp_pkg::ST_ABNORMAL] = 1'b1;
                        nxt_ff.state = S_READ;
                    end
                end
            end
            S_LOAD: begin
                // Later address lines are ignored; only data counts.
                if (wr_edge) begin
                    if (cur_ff.count == 8'(fpp_pkg::PAGE_BYTES - 1)) begin
                        nxt_ff.op_addr = cur_ff.page_addr;
                        nxt_ff.timer = '0;
                        nxt_ff.done = 1'b0;
                        nxt_ff.state = S_PROG;
                    end
                    nxt_ff.count = cur_ff.count + 8'h01;
                end
            end
            S_PROG: begin
                // One byte per cycle, then hold on the last byte until the write time, counted from entry, ends.
                if (cur_ff.op_addr[6:0] != 7'h7f) begin
                    nxt_ff.op_addr = cur_ff.op_addr + AW'(1);
                end
                nxt_ff.timer = cur_ff.timer + 32'h1;
                if (cur_ff.timer >= PROG_CYC - 1) begin
                    nxt_ff.done = 1'b1;
                    nxt_ff.state = S_POLL;
                end
            end
            S_ERASE: begin
                if (cur_ff.op_addr != AW'(FLASH_BYTES - 1)) begin
                    nxt_ff.op_addr = cur_ff.op_addr + AW'(1);
                end
                nxt_ff.timer = cur_ff.timer + 32'h1;
                if (cur_ff.timer >= ERASE_CYC - 1) begin
                    nxt_ff.done = 1'b1;
                    nxt_ff.state = S_POLL;
                end
            end
            default: nxt_ff.state = S_OSC;
        endcase
        if (!nrst_in) begin
            nxt_ff.state = S_OSC;
            nxt_ff.timer = '0;
            nxt_ff.first_cmd = fpp_pkg::CMD_READ;
            nxt_ff.count = 8'h00;
            nxt_ff.page_addr = '0;
            nxt_ff.op_addr = '0;
            nxt_ff.status = fpp_pkg::STATUS_RESET;
            nxt_ff.done = 1'b0;
            nxt_ff.we_d = 1'b0;
            nxt_ff.rd_byte = 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Register the whole sequencer state.
    always_ff @(posedge sys_clk_in) begin
        cur_ff <= nxt_ff;
    end

    ////////////////////////////////////////////////////////////////////
    // Read data selection: array byte, status byte, or polling byte
    // whose bit 6 reads one on normal end and the abnormal flag on bit 7.
    always_comb begin
        case (cur_ff.state)
            S_STATUS: data_out = cur_ff.status;
            S_POLL, S_PROG, S_ERASE: begin
                data_out = 8'h00;
                data_out[7] = cur_ff.status[fpp_pkg::ST_ABNORMAL];
                data_out[6] = cur_ff.done &&
                    !cur_ff.status[fpp_pkg::ST_ABNORMAL];
            end
            default: data_out = cur_ff.rd_byte;
        endcase
    end

    // Drive only for a selected read; deselect floats but keeps running.
    assign data_oe_out = !chip_sel_n_in && !out_en_n_in && write_n_in;
    assign ready_out = cur_ff.state != S_OSC && cur_ff.state != S_SETUP;
    assign busy_out = cur_ff.state == S_PROG || cur_ff.state == S_ERASE;

endmodule

/* dv/fpp_top_asserts.sv */
/* Checks on the flash programming port at its top level ports.
   Assumes a bind to fpp_top; it sees the ports and nothing else. */
module fpp_top_asserts #(
    parameter int unsigned AW = 17,
    parameter int unsigned OSC_CYC = 8,
    parameter int unsigned SETUP_CYC = 8,
    parameter int unsigned PROG_CYC = 200,
    parameter int unsigned ERASE_CYC = 300
) (
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    input wire logic chip_sel_n_in,
    input wire logic out_en_n_in,
    input wire logic write_n_in,
    input wire logic [AW-1:0] addr_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe_out,
    input wire logic ready_out,
    input wire logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SET = OSC_CYC + SETUP_CYC;
    int unsigned rcnt_ff;
    int unsigned bcnt_ff;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);
    // Counts cycles since reset and the length of the current busy spell.
    always_ff @(posedge sys_clk_in) begin
        rcnt_ff <= !nrst_in ? 0 : rcnt_ff + ((rcnt_ff < 999) ? 1 : 0);
        bcnt_ff <= (!nrst_in || !busy_out) ? 0 : bcnt_ff + 1;
    end
    ////////////////////////////////////////////////////////////
    // The byte lines are driven only in the read strobe state.
    property p_oe;
        data_oe_out == (!chip_sel_n_in && !out_en_n_in && write_n_in);
    endproperty
    a_oe: assert property (p_oe) else $error("bad data enable");
    property p_desel; chip_sel_n_in |-> !data_oe_out; endproperty
    a_desel: assert property (p_desel) else $error("driven deselected");
    property p_early; (rcnt_ff + 2 < SET) |-> !ready_out; endproperty
    a_early: assert property (p_early) else $error("ready too soon");
    property p_late; (rcnt_ff > SET + 2) |-> ready_out; endproperty
    a_late: assert property (p_late) else $error("ready too late");
    property p_stay; ready_out |=> ready_out; endproperty
    a_stay: assert property (p_stay) else $error("ready dropped");
    property p_bready; busy_out |-> ready_out; endproperty
    a_bready: assert property (p_bready) else $error("busy not ready");
    property p_bmin; $rose(busy_out) |=> busy_out[*8]; endproperty
    a_bmin: assert property (p_bmin) else $error("busy too short");
    // A busy spell lasts the program time or the erase time.
    property p_blen;
        $fell(busy_out) |->
            (bcnt_ff + 1 >= PROG_CYC && bcnt_ff <= PROG_CYC + 1)
            || (bcnt_ff + 1 >= ERASE_CYC && bcnt_ff <= ERASE_CYC + 1);
    endproperty
    a_blen: assert property (p_blen) else $error("busy length off");
    property p_hold;
        (data_oe_out && !busy_out && $stable(addr_in))[*3]
            |=> (!data_oe_out || $stable(data_out));
    endproperty
    a_hold: assert property (p_hold) else $error("read byte moved");
    c_ready: cover property ($rose(ready_out));
    c_done: cover property ($fell(busy_out));
    c_read: cover property (data_oe_out && ready_out);
endmodule

/* dv/fpp_prog_model.sv */
/* Behavioural programming instrument on the far side of the byte port.
   Assumes the bench calls one task at a time. */
module fpp_prog_model #(
    parameter int unsigned AW = 17
) (
    input wire logic sys_clk_in,
    input wire logic [7:0] data_in,
    output logic chip_sel_n_out,
    output logic out_en_n_out,
    output logic write_n_out,
    output logic write_protect_release_pin_out,
    output logic [AW-1:0] addr_out,
    output logic [7:0] data_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port: deselected, strobes high, protect pin low.
    initial begin
        chip_sel_n_out = 1'b1;
        out_en_n_out = 1'b1;
        write_n_out = 1'b1;
        write_protect_release_pin_out = 1'b0;
        addr_out = '0;
        data_out = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    // Write strobe low one cycle; data held over the rising edge.
    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d,
                      input logic p);
        @(posedge sys_clk_in);
        chip_sel_n_out <= 1'b0;
        write_n_out <= 1'b0;
        write_protect_release_pin_out <= p;
        addr_out <= a;
        data_out <= d;
        @(posedge sys_clk_in);
        write_n_out <= 1'b1;
        @(posedge sys_clk_in);
        chip_sel_n_out <= 1'b1;
        addr_out <= ~a;
        data_out <= ~d;
    endtask
    // Read: select and output enable low, address stable, then sample.
    task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        chip_sel_n_out <= 1'b0;
        out_en_n_out <= 1'b0;
        addr_out <= a;
        repeat (3) @(posedge sys_clk_in);
        #1 d = data_in;
        @(posedge sys_clk_in);
        chip_sel_n_out <= 1'b1;
        out_en_n_out <= 1'b1;
    endtask
endmodule

/* dv/flash_parallel_programmer_mode_test.sv */
/* Self-checking bench for the flash programming port.
   Assumes the package and the programmer model are compiled first. */
module flash_parallel_programmer_mode_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned AW = 9;
    localparam int unsigned FB = 256;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic cs_n, oe_n, we_n, wp, oe, ready, busy;
    logic [AW-1:0] addr;
    logic [7:0] din, dout, got, st;
    int mismatches = 0;
    int comparisons = 0;
    int mem [int];
    // Free running system clock.
    always #5 sys_clk_in = ~sys_clk_in;
    fpp_top #(.AW(AW), .FLASH_BYTES(FB), .OSC_CYC(8), .SETUP_CYC(8),
        .PROG_CYC(200), .ERASE_CYC(300)) dut (.sys_clk_in(sys_clk_in),
        .nrst_in(nrst_in), .chip_sel_n_in(cs_n), .out_en_n_in(oe_n),
        .write_n_in(we_n), .write_protect_release_pin_in(wp),
        .addr_in(addr), .data_in(din), .data_out(dout),
        .data_oe_out(oe), .ready_out(ready), .busy_out(busy));
    fpp_prog_model #(.AW(AW)) pm (.sys_clk_in(sys_clk_in),
        .data_in(dout), .chip_sel_n_out(cs_n), .out_en_n_out(oe_n),
        .write_n_out(we_n), .write_protect_release_pin_out(wp),
        .addr_out(addr), .data_out(din));
    ////////////////////////////////////////////////////////////
    // Compare helpers: count and report differences.
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_bit(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    // Waits out busy under a bound, then checks the poll byte.
    task automatic finish_op(input logic [7:0] e);
        int k;
        for (k = 0; k < 20 && busy !== 1'b1; k++) @(posedge sys_clk_in) #1;
        cmp_bit(busy, 1'b1);
        for (k = 0; k < 999 && busy !== 1'b0; k++) @(posedge sys_clk_in) #1;
        cmp_bit(busy, 1'b0);
        pm.rd('0, got);
        cmp_byte(got & 8'hc0, e);
    endtask
    // Enters status read mode and checks the status byte.
    task automatic status(input logic [7:0] e);
        pm.wr('0, fpp_pkg::CMD_STATUS, 1'b1);
        pm.wr('0, fpp_pkg::CMD_STATUS, 1'b1);
        pm.rd('0, got);
        cmp_byte(got, e);
    endtask
    // Reads the whole array back in byte read mode.
    task automatic check_all();
        int a;
        pm.wr('0, fpp_pkg::CMD_READ, 1'b0);
        for (a = 0; a < FB; a++) begin
            pm.rd(AW'(a), got);
            cmp_byte(got, 8'(mem[a]));
        end
    endtask
    // Sends one page; the tail is padded, later addresses are noise.
    task automatic write_page(input logic [AW-1:0] pa);
        logic [7:0] d;
        int k;
        pm.wr('0, fpp_pkg::CMD_PROGRAM, 1'b1);
        for (k = 0; k < fpp_pkg::PAGE_BYTES; k++) begin
            d = (k > 100) ? fpp_pkg::ERASED_BYTE : 8'($urandom);
            pm.wr((k == 0) ? pa : AW'($urandom), d, 1'b1);
            if (pa < FB) mem[int'(pa) + k] = d;
        end
    endtask
    // Prints the verdict and ends the run.
    task automatic conclude();
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Cuts a hang short.
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h0b3e0989));
        st = 8'((1 << fpp_pkg::ST_ABNORMAL) | (1 << fpp_pkg::ST_PROG_ERR)
            | (1 << fpp_pkg::ST_ADDR_ERR));
        repeat (12) @(posedge sys_clk_in);
        nrst_in <= 1'b1;
        pm.wr('0, fpp_pkg::CMD_ERASE, 1'b1);
        pm.wr('0, fpp_pkg::CMD_ERASE, 1'b1);
        repeat (3) @(posedge sys_clk_in) #1;
        cmp_bit(busy, 1'b0);
        repeat (20) @(posedge sys_clk_in) #1;
        cmp_bit(ready, 1'b1);
        cmp_bit(oe, 1'b0);
        pm.wr('0, fpp_pkg::CMD_ERASE, 1'b1);
        pm.wr('0, fpp_pkg::CMD_ERASE, 1'b1);
        finish_op(8'h40);
        for (int a = 0; a < FB; a++) mem[a] = fpp_pkg::ERASED_BYTE;
        status(8'h00);
        check_all();
        write_page(9'h080);
        finish_op(8'h40);
        status(fpp_pkg::STATUS_RESET);
        check_all();
        write_page(9'h100);
        finish_op(8'h80);
        status(st);
        pm.rd('0, got);
        cmp_byte(got, st);
        check_all();
        pm.wr('0, fpp_pkg::CMD_PROGRAM, 1'b0);
        status(st | 8'h40);
        pm.wr('0, 8'h55, 1'b1);
        status(st | 8'h40);
        conclude();
    end
endmodule

bind fpp_top fpp_top_asserts #(.AW(AW), .OSC_CYC(OSC_CYC),
    .SETUP_CYC(SETUP_CYC), .PROG_CYC(PROG_CYC), .ERASE_CYC(ERASE_CYC))
    u_chk (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .chip_sel_n_in(chip_sel_n_in), .out_en_n_in(out_en_n_in),
    .write_n_in(write_n_in), .addr_in(addr_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .ready_out(ready_out), .busy_out(busy_out));
